// >>> design/jsbc_pkg.sv
package jsbc_pkg;
  localparam int W = 24;
  // opcode patterns in first word bits 23..14; bit 5 clear tells them from the set variant
  localparam logic [9:0] OP_EA = 10'h02D;
  localparam logic [9:0] OP_AA = 10'h02C;
  localparam logic [9:0] OP_PP = 10'h02E;
  localparam logic [9:0] OP_QQ = 10'h007;
  localparam logic [9:0] OP_REG = 10'h02F;
  localparam int BIT_LO = 0;
  localparam int BIT_HI = 4;
  localparam int SEL_LO = 8;
  localparam int SEL_HI = 13;
  localparam int MEM_BIT = 7;
  localparam int SPACE_BIT = 6;
  localparam int SETJ_BIT = 5;
  localparam logic [4:0] MAX_BIT = 5'h17;
  localparam logic [23:0] HIGH_IO_BASE = 24'hFFFFC0;
  localparam logic [23:0] LOW_IO_BASE = 24'hFFFF80;
  localparam int CCR_S = 7;
  localparam int CCR_L = 6;
  localparam logic [23:0] SR_RESET = 24'hC00300;
  localparam logic [23:0] PC_RESET = 24'h000000;
  localparam logic [5:0] SP_RESET = 6'h00;
  typedef enum logic [2:0] {
    JSBC_IDLE, JSBC_EXT, JSBC_OPND, JSBC_WAIT, JSBC_DONE
  } jsbc_state_e;
endpackage

// >>> design/jsbc_call_if_bit_zero.sv
// Behaviour
// RULE1: bit zero means continue at the 24-bit address in the extension word.
// RULE2: five-bit index in low bits selects tested bit, valid positions 0 to 23.
// RULE3: taken call bumps stack pointer, pushes return address high, status low.
// RULE4: bit one: step to next instruction, ignore extension, stack untouched.
// RULE5: address register update of the ea mode happens whether taken or not.
// RULE6: operand via any register indirect mode, absolute short 0-63, both I/O shorts.
// RULE7: only scaling and limit flags change; condition bits 5..0 kept.
// RULE8: indirect form: bits 13..8 are mode and register selector, bit 7 set.
// RULE9: bit 6 picks X or Y data space for every memory operand form.
// RULE10: high I/O short field maps onto FFFFC0 to FFFFFF.
// RULE11: low I/O short field maps onto FFFF80 to FFFFBF.
// RULE12: register form: six-bit direct register selector, bits 7 and 6 zero.
// RULE13: two 24-bit words; second word fetched as full branch target.
`timescale 1ns/100ps
`default_nettype none
module jsbc_call_if_bit_zero (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic [23:0] pc_in,
  input wire logic [23:0] status_register_in,
  input wire logic [5:0] stack_pointer_in,
  input wire logic ext_valid,
  input wire logic [23:0] ext_word,
  output logic ext_req,
  output logic ea_req,
  output logic [5:0] mode_register_selector,
  input wire logic ea_valid,
  input wire logic [23:0] ea_addr,
  output logic ea_update,
  output logic mem_req,
  output logic mem_space_y,
  output logic [23:0] mem_addr,
  input wire logic mem_valid,
  input wire logic [23:0] mem_data,
  output logic reg_req,
  output logic [5:0] direct_register_selector,
  input wire logic reg_valid,
  input wire logic [23:0] reg_data,
  input wire logic scale_flag,
  input wire logic limit_flag,
  output logic done,
  output logic illegal,
  output logic taken,
  output logic [23:0] pc_out,
  output logic [5:0] stack_pointer_out,
  output logic stack_we,
  output logic [23:0] stack_high_word,
  output logic [23:0] stack_low_word,
  output logic [23:0] status_register_out
);
  jsbc_pkg::jsbc_state_e state_r;
  logic [23:0] iw_r;
  logic [23:0] target_r;
  logic [23:0] pc_r;
  logic [23:0] sr_r;
  logic [5:0] sp_r;
  logic [9:0] opc;
  logic is_ea;
  logic is_aa;
  logic is_pp;
  logic is_qq;
  logic is_reg;
  logic fmt_ok;
  logic accept;
  logic iw_is_reg;
  logic [4:0] bit_idx;
  logic [23:0] opnd;
  logic opnd_valid;
  logic bit_clear;
  logic finish;
  logic [5:0] short_field;
  logic [23:0] short_addr;
  logic [23:0] ret_addr;
  logic [23:0] sr_merged;

  assign opc = instr_word[23:14];
  assign short_field = instr_word[jsbc_pkg::SEL_HI:jsbc_pkg::SEL_LO];

  // opcode alone is not enough: bit 7 tells memory forms from the register form
  always_comb begin
    is_ea = 1'b0;
    is_aa = 1'b0;
    is_pp = 1'b0;
    is_qq = 1'b0;
    is_reg = 1'b0;
    case (opc)
      jsbc_pkg::OP_EA: begin
        is_ea = instr_word[jsbc_pkg::MEM_BIT]; // [RULE8]
      end
      jsbc_pkg::OP_AA: begin
        is_aa = instr_word[jsbc_pkg::MEM_BIT]; // [RULE6]
      end
      jsbc_pkg::OP_PP: begin
        is_pp = instr_word[jsbc_pkg::MEM_BIT]; // [RULE10]
      end
      jsbc_pkg::OP_QQ: begin
        is_qq = instr_word[jsbc_pkg::MEM_BIT]; // [RULE11]
      end
      jsbc_pkg::OP_REG: begin
        is_reg = (instr_word[7:6] == 2'b00); // [RULE12]
      end
      default: begin
        is_reg = 1'b0;
      end
    endcase
  end

  // bit 5 set belongs to the set variant, indices above 23 name no bit
  always_comb begin
    fmt_ok = is_ea || is_aa || is_pp || is_qq || is_reg; // [RULE6]
    if (instr_word[jsbc_pkg::SETJ_BIT]) begin
      fmt_ok = 1'b0;
    end
    if (instr_word[jsbc_pkg::BIT_HI:jsbc_pkg::BIT_LO] > jsbc_pkg::MAX_BIT) begin
      fmt_ok = 1'b0; // [RULE2]
    end
  end

  assign accept = (state_r == jsbc_pkg::JSBC_IDLE) && instr_valid && fmt_ok;

  // short forms carry six address bits; the I/O forms fill the top from a fixed base
  always_comb begin
    short_addr = {18'h00000, short_field}; // [RULE6]
    if (is_pp) begin
      short_addr = jsbc_pkg::HIGH_IO_BASE | {18'h00000, short_field}; // [RULE10]
    end else if (is_qq) begin
      short_addr = jsbc_pkg::LOW_IO_BASE | {18'h00000, short_field}; // [RULE11]
    end
  end

  assign iw_is_reg = (iw_r[23:14] == jsbc_pkg::OP_REG);
  assign bit_idx = iw_r[jsbc_pkg::BIT_HI:jsbc_pkg::BIT_LO]; // [RULE2]

  always_comb begin
    if (iw_is_reg) begin
      opnd = reg_data; // [RULE12]
      opnd_valid = reg_valid;
    end else begin
      opnd = mem_data; // [RULE9]
      opnd_valid = mem_valid;
    end
  end

  // operand only counts in the wait state; an early answer must be held by the far side
  assign finish = (state_r == jsbc_pkg::JSBC_WAIT) && opnd_valid;
  assign bit_clear = !opnd[bit_idx]; // [RULE1]
  // two-word instruction, so the return point is two words on
  assign ret_addr = pc_r + 24'h000002; // [RULE13]
  assign sr_merged = {sr_r[23:8], scale_flag, limit_flag, sr_r[5:0]}; // [RULE7]

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= jsbc_pkg::JSBC_IDLE;
    end else begin
      case (state_r)
        jsbc_pkg::JSBC_IDLE: begin
          if (accept) begin
            state_r <= jsbc_pkg::JSBC_EXT;
          end
        end
        jsbc_pkg::JSBC_EXT: begin
          if (ext_valid) begin
            state_r <= jsbc_pkg::JSBC_OPND;
          end
        end
        jsbc_pkg::JSBC_OPND: begin
          state_r <= jsbc_pkg::JSBC_WAIT;
        end
        jsbc_pkg::JSBC_WAIT: begin
          if (opnd_valid) begin
            state_r <= jsbc_pkg::JSBC_DONE;
          end
        end
        jsbc_pkg::JSBC_DONE: begin
          state_r <= jsbc_pkg::JSBC_IDLE;
        end
        default: begin
          state_r <= jsbc_pkg::JSBC_IDLE;
        end
      endcase
    end
  end

  // instruction context is frozen at accept so the core may move on
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      iw_r <= 24'h000000;
      pc_r <= jsbc_pkg::PC_RESET;
      sr_r <= jsbc_pkg::SR_RESET;
      sp_r <= jsbc_pkg::SP_RESET;
    end else if (accept) begin
      iw_r <= instr_word;
      pc_r <= pc_in;
      sr_r <= status_register_in;
      sp_r <= stack_pointer_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      target_r <= 24'h000000;
    end else if (state_r == jsbc_pkg::JSBC_EXT && ext_valid) begin
      target_r <= ext_word; // [RULE13]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_req <= 1'b0;
    end else begin
      ext_req <= accept; // [RULE13]
    end
  end

  // address unit answers first; its update is committed before the bit is known
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ea_req <= 1'b0;
      ea_update <= 1'b0;
      mode_register_selector <= 6'h00;
    end else begin
      ea_update <= 1'b0;
      if (accept) begin
        ea_req <= is_ea;
        mode_register_selector <= short_field; // [RULE8]
      end else if (ea_req && ea_valid) begin
        ea_req <= 1'b0;
        ea_update <= 1'b1; // [RULE5]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_req <= 1'b0;
      mem_space_y <= 1'b0;
      mem_addr <= 24'h000000;
    end else if (accept) begin
      mem_req <= is_aa || is_pp || is_qq;
      mem_space_y <= instr_word[jsbc_pkg::SPACE_BIT]; // [RULE9]
      mem_addr <= short_addr; // [RULE6]
    end else if (ea_req && ea_valid) begin
      mem_req <= 1'b1;
      mem_addr <= ea_addr; // [RULE6]
    end else if (finish) begin
      mem_req <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_req <= 1'b0;
      direct_register_selector <= 6'h00;
    end else if (accept) begin
      reg_req <= is_reg;
      direct_register_selector <= short_field; // [RULE12]
    end else if (finish) begin
      reg_req <= 1'b0;
    end
  end

  // one-cycle strobes, cleared every cycle unless set again
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      done <= finish;
      illegal <= (state_r == jsbc_pkg::JSBC_IDLE) && instr_valid && !fmt_ok;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      taken <= 1'b0;
      pc_out <= jsbc_pkg::PC_RESET;
      status_register_out <= jsbc_pkg::SR_RESET;
    end else if (finish) begin
      taken <= bit_clear;
      status_register_out <= sr_merged; // [RULE7]
      if (bit_clear) begin
        pc_out <= target_r; // [RULE1]
      end else begin
        // extension word is dropped on a skip
        pc_out <= ret_addr; // [RULE4]
      end
    end
  end

  // a skip leaves the stack as it was, pointer included
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stack_pointer_out <= jsbc_pkg::SP_RESET;
      stack_we <= 1'b0;
      stack_high_word <= 24'h000000;
      stack_low_word <= 24'h000000;
    end else begin
      stack_we <= finish && bit_clear; // [RULE3]
      if (finish && bit_clear) begin
        stack_pointer_out <= sp_r + 6'h01; // [RULE3]
        stack_high_word <= ret_addr; // [RULE3]
        stack_low_word <= sr_r; // [RULE3]
      end else if (finish) begin
        stack_pointer_out <= sp_r; // [RULE4]
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/jsbc_props_properties.sv
`timescale 1ns/100ps
`default_nettype none
module jsbc_props (
  input wire logic sys_clk, reset, instr_valid, mem_req, mem_space_y, done, taken, stack_we,
  input wire logic illegal,
  input wire logic [23:0] instr_word, pc_in, status_register_in, mem_addr, pc_out,
  input wire logic [23:0] stack_high_word, stack_low_word, status_register_out
);
  logic bsy_r;
  logic [23:0] iw_r, pc_r, sr_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // a refused word frees the tracker one cycle later, through illegal
  always_ff @(posedge sys_clk) bsy_r <= !reset && !done && !illegal && (bsy_r || instr_valid);
  // words of the accepted instruction, kept for the whole operation
  always_ff @(posedge sys_clk)
    if (instr_valid && !bsy_r) {iw_r, pc_r, sr_r} <= {instr_word, pc_in, status_register_in};
  chk_call_push: assert property (done && taken |-> stack_we) else $error("no push");
  chk_skip_next: assert property (done && !taken |-> !stack_we && pc_out == pc_r + 24'h2)
    else $error("bad skip");
  chk_push_ret: assert property (stack_we |-> stack_high_word == pc_r + 24'h2)
    else $error("bad return word");
  chk_push_sr: assert property (stack_we |-> stack_low_word == sr_r) else $error("bad sr");
  chk_ccr_kept: assert property (done |-> status_register_out[5:0] == sr_r[5:0])
    else $error("ccr low bits");
  chk_space_pick: assert property (mem_req |-> mem_space_y == iw_r[6]) else $error("space");
  chk_high_io: assert property (mem_req && iw_r[23:14] == 10'h02E |->
    mem_addr == {18'h3FFFF, iw_r[13:8]}) else $error("high io");
  chk_low_io: assert property (mem_req && iw_r[23:14] == 10'h007 |->
    mem_addr == {18'h3FFFE, iw_r[13:8]}) else $error("low io");
endmodule
bind jsbc_call_if_bit_zero jsbc_props chk_i (.*);
`default_nettype wire

// >>> verif/jsbc_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module jsbc_far_model (
  input wire logic sys_clk, reset, ext_req, ea_req, mem_req, reg_req, done,
  input wire logic [23:0] opnd, xw,
  output logic ext_valid, ea_valid, mem_valid, reg_valid,
  output logic [23:0] ext_word, ea_addr, mem_data, reg_data
);
  logic bsy_r, ok;
  logic [1:0] cnt_r;
  always_ff @(posedge sys_clk) bsy_r <= !reset && !done && (bsy_r || ext_req);
  // latency 0..3 from the target word, so prompt and slow answers both occur
  always_ff @(posedge sys_clk) cnt_r <= bsy_r ? cnt_r + 2'(cnt_r != xw[2:1]) : 2'h0;
  assign ok = bsy_r && cnt_r == xw[2:1];
  assign ext_valid = ok;
  assign ext_word = ok ? xw : ~xw;
  assign ea_valid = ok && ea_req;
  assign ea_addr = ea_valid ? ~xw : xw;
  assign mem_valid = ok && mem_req;
  assign mem_data = mem_valid ? opnd : ~opnd;
  assign reg_valid = ok && reg_req;
  assign reg_data = reg_valid ? opnd : ~opnd;
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk = 0, reset = 1, instr_valid = 0, scale_flag = 0, limit_flag = 0, upd_r = 0;
  logic tk, ext_valid, ea_valid, mem_valid, reg_valid, ext_req, ea_req, ea_update, mem_req;
  logic reg_req, mem_space_y, done, illegal, taken, stack_we;
  logic [23:0] instr_word = 0, pc_in = 0, status_register_in = 0, opnd = 0, xw = 0, ea_x, sx;
  logic [23:0] ext_word, ea_addr, mem_data, reg_data, mem_addr, pc_out, stack_high_word;
  logic [23:0] stack_low_word, status_register_out;
  logic [5:0] stack_pointer_in = 0, fld, stack_pointer_out, mode_register_selector;
  logic [5:0] direct_register_selector;
  logic [9:0] opc [5] = '{10'h02D, 10'h02C, 10'h02E, 10'h007, 10'h02F};
  int miscompares = 0, checks_done = 0, seed = 72866, k, n, f, t;
  jsbc_call_if_bit_zero DUT (.*);
  jsbc_far_model far (.*);
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) upd_r <= ea_update || (upd_r && !instr_valid);
  function automatic logic [23:0] rnd();
    return 24'($random(seed));
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    reset = 0;
    for (k = 0; k < 60; k++) begin
      @(negedge sys_clk);
      f = k % 5;
      n = k % 7 < 2 ? 23 * (k % 7) : rnd() % 24;
      {xw, opnd, pc_in, status_register_in} = {rnd(), rnd(), rnd(), rnd()};
      {limit_flag, scale_flag, stack_pointer_in, fld} = 14'(rnd());
      if (f == 0) fld[5:3] = 3'(k / 5 % 5);
      sx = {status_register_in[23:8], scale_flag, limit_flag, status_register_in[5:0]};
      ea_x = f == 0 ? ~xw : {f == 1 ? 18'h0 : f == 2 ? 18'h3FFFF : 18'h3FFFE, fld};
      instr_word = {opc[f], fld, f != 4, f != 4 && xw[0], 1'b0, 5'(n)};
      tk = !opnd[n];
      instr_valid = 1;
      @(negedge sys_clk) instr_valid = 0;
      for (t = 0; t < 40 && done !== 1'b1; t++) @(negedge sys_clk);
      if (t == 40) begin
        miscompares++;
        give_verdict();
      end
      chk(taken, tk);
      chk(pc_out, tk ? xw : 24'(pc_in + 24'h2));
      chk(status_register_out, sx);
      chk(stack_pointer_out, tk ? 6'(stack_pointer_in + 6'h1) : stack_pointer_in);
      chk(stack_we, tk);
      if (tk) chk(stack_high_word, 24'(pc_in + 24'h2));
      if (tk) chk(stack_low_word, status_register_in);
      if (f == 4) chk(direct_register_selector, fld);
      else chk({mem_space_y, mem_addr}, {xw[0], ea_x});
      chk({upd_r, mode_register_selector}, {f == 0, fld});
    end
    // refused words: bit index 24, then bit 5 set
    for (k = 0; k < 2; k++) begin
      @(negedge sys_clk);
      instr_word = {opc[k], 6'h05, 2'b10, k[0] ? 6'h21 : 6'h18};
      instr_valid = 1;
      @(negedge sys_clk) instr_valid = 0;
      chk(illegal, 1'b1);
      repeat (6) @(negedge sys_clk);
      chk({done, ext_req}, 2'b00);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
